//--- shared/ssadc_pkg.sv
/*
  Constants, types and register map of the single-slope converter timer.
  Assumes one 250 MHz clock that is also the instruction clock.
*/
package ssadc_pkg;
  localparam int CHANNELS    = 4;
  localparam int COUNT_WIDTH = 12;
  localparam int ADDR_WIDTH  = 4;
  localparam int DATA_WIDTH  = 16;
  localparam int WIDTH_BITS  = 8;

  localparam logic [COUNT_WIDTH-1:0] COUNT_MAX  = 12'hfff;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 12'h000;

  // Register offsets
  localparam logic [ADDR_WIDTH-1:0] MODE_OFFSET   = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] WIDTH_OFFSET  = 4'h1;
  localparam logic [ADDR_WIDTH-1:0] TRIM_OFFSET   = 4'h2;
  localparam logic [ADDR_WIDTH-1:0] SHUT_OFFSET   = 4'h3;
  localparam logic [ADDR_WIDTH-1:0] RESULT_OFFSET = 4'h4;

  // Field positions in mode_control_reg
  localparam int SEL_LO_BIT = 0;
  localparam int SEL_HI_BIT = 1;
  localparam int RATE_BIT   = 7;
  localparam int DOUBLE_BIT = 9;

  // Field positions in the shutdown register
  localparam int SHUT_BIT   = 0;
  localparam int REINIT_BIT = 1;
  localparam int TRIP_BIT   = 1;
  localparam int SWSRC_BIT  = 2;

  // Reset values and the reference select code
  localparam logic [2:0]            TRIM_RESET  = 3'h0;
  localparam logic [WIDTH_BITS-1:0] WIDTH_RESET = 8'h80;
  localparam logic [1:0]            SEL_REF     = 2'h3;

  // Shortest cycle pulse, rounded up to whole clocks
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int MIN_PULSE_PS   = 50000;
  localparam int MIN_PULSE_CYC  = (MIN_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [WIDTH_BITS-1:0] MIN_PULSE = WIDTH_BITS'(MIN_PULSE_CYC);

  typedef struct packed {
    logic       doubleUpdate;
    logic       rateFull;
    logic [1:0] auxSelect;
  } mode_type;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
  } bus_req_type;

  typedef enum logic [1:0] {
    PH_IDLE      = 2'b00,
    PH_DISCHARGE = 2'b01,
    PH_CONVERT   = 2'b10
  } phase_type;
endpackage

//--- hw/ramp_counter.sv
/*
  Shared conversion timer: clears to zero, advances at full or half rate,
  stops at its top count. Assumes clear and run come from the same clock.
*/
`timescale 1ns/1ps
module ramp_counter (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // Control
  input  wire logic                           clear,
  input  wire logic                           run,
  input  wire logic                           rateFull,
  // Count
  output logic [ssadc_pkg::COUNT_WIDTH-1:0]   count
);
  import ssadc_pkg::*;

  logic halfPhase;
  wire  step    = run && (rateFull || halfPhase);
  wire  atTop   = (count == COUNT_MAX);

  // Half-rate phase only toggles while counting, so every period starts on the same phase
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      halfPhase <= 1'b0;
    end else if (run) begin
      halfPhase <= !halfPhase;
    end
  end

  // Saturating timer: a slow ramp stops at 4095 rather than wrapping
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      count <= COUNT_ZERO;
    end else if (step && !atTop) begin
      count <= count + 12'h001;
    end
  end
endmodule

//--- hw/single_slope_adc_timer.sv
/*
  Control and timing of the four-channel single-slope converter: cycle
  pulse, shared timer, per-channel capture, shutdown and registers.
  Assumes comparator and trip pins are asynchronous, and that the PWM
  timer gives one-clock start and midpoint strobes on this clock.
*/
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module single_slope_adc_timer (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // Register port
  input  wire ssadc_pkg::bus_req_type              busReq,
  output logic [ssadc_pkg::DATA_WIDTH-1:0]         rdData,
  // PWM timer strobes
  input  wire logic                                pwmStart,
  input  wire logic                                pwmMidpoint,
  // Fault pin, low means trip
  input  wire logic                                faultTripInput_n,
  // Comparator outputs, high once input is below the ramp
  input  wire logic [ssadc_pkg::CHANNELS-1:0]      compTrip,
  // Analog controls
  output logic                                     pwmCyclePulse,
  output logic [1:0]                               auxSelect,
  output logic [2:0]                               rampCurrentTrim
);
  import ssadc_pkg::*;

  // Register state
  mode_type               mode;
  logic [WIDTH_BITS-1:0]  cyclePulseWidth;
  logic                   shutdown;
  logic                   swSource;

  // Sequencer state
  phase_type              phase;
  phase_type              next_phase;
  logic [WIDTH_BITS-1:0]  pulseLeft;

  // Synchronisers
  logic                   tripMeta;
  logic                   tripSync;
  logic [CHANNELS-1:0]    compMeta;
  logic [CHANNELS-1:0]    compSync;
  logic [CHANNELS-1:0]    compLast;

  // Capture state
  logic [COUNT_WIDTH-1:0] capture [CHANNELS];
  logic [COUNT_WIDTH-1:0] result  [CHANNELS];
  logic [CHANNELS-1:0]    captured;
  logic [COUNT_WIDTH-1:0] count;

  // Address decode
  wire hitMode   = (busReq.addr == MODE_OFFSET);
  wire hitWidth  = (busReq.addr == WIDTH_OFFSET);
  wire hitTrim   = (busReq.addr == TRIM_OFFSET);
  wire hitShut   = (busReq.addr == SHUT_OFFSET);
  wire hitResult = (busReq.addr[ADDR_WIDTH-1:2] == RESULT_OFFSET[ADDR_WIDTH-1:2]);
  wire [1:0] resultIdx = busReq.addr[1:0];

  wire wrMode   = busReq.wr && hitMode;
  wire wrWidth  = busReq.wr && hitWidth;
  wire wrTrim   = busReq.wr && hitTrim;
  wire wrShut   = busReq.wr && hitShut;
  wire rdShut   = busReq.rd && hitShut;

  // Shutdown requests and release
  wire swShutReq = wrShut && busReq.wdata[SHUT_BIT];
  wire reinitReq = wrShut && busReq.wdata[REINIT_BIT];
  wire tripLow   = !tripSync;
  wire shutSet   = tripLow || swShutReq;
  wire shutClr   = reinitReq && tripSync;

  // Sync events: start of cycle, plus midpoint in double update mode
  wire syncEvent = pwmStart || (mode.doubleUpdate && pwmMidpoint);
  wire goCycle   = syncEvent && !shutdown && !shutSet;

  // Pulse length, never below the shortest discharge time
  wire [WIDTH_BITS-1:0] pulseLoad =
    (cyclePulseWidth < MIN_PULSE) ? MIN_PULSE : cyclePulseWidth;
  wire pulseDone = (pulseLeft == 8'h01);

  // Period ends on the next sync event or on shutdown
  wire periodEnd = (phase == PH_CONVERT) && (syncEvent || shutSet || shutdown);
  wire counting  = (phase == PH_CONVERT);
  wire clearCnt  = (next_phase == PH_DISCHARGE);

  // Fresh trips seen by each comparator
  wire [CHANNELS-1:0] tripEdge = compSync & ~compLast;

  // Sequencer next state
  always_comb begin
    next_phase = phase;
    case (phase)
      PH_IDLE: begin
        if (goCycle) begin
          next_phase = PH_DISCHARGE;
        end
      end
      PH_DISCHARGE: begin
        if (shutSet || shutdown) begin
          next_phase = PH_IDLE;
        end else if (goCycle) begin
          next_phase = PH_DISCHARGE;
        end else if (pulseDone) begin
          next_phase = PH_CONVERT;
        end
      end
      PH_CONVERT: begin
        if (shutSet || shutdown) begin
          next_phase = PH_IDLE;
        end else if (goCycle) begin
          next_phase = PH_DISCHARGE;
        end
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase <= PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // Pulse width countdown, reloaded on each new cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulseLeft <= MIN_PULSE;
    end else if (goCycle) begin
      pulseLeft <= pulseLoad;
    end else if (phase == PH_DISCHARGE && !pulseDone) begin
      pulseLeft <= pulseLeft - 8'h01;
    end
  end

  // Discharge pulse to the ramp capacitor, one flop to the pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwmCyclePulse <= 1'b0;
    end else begin
      pwmCyclePulse <= (next_phase == PH_DISCHARGE);
    end
  end

  // One timer for all channels, held at zero while discharging
  ramp_counter timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .clear    (clearCnt),
    .run      (counting),
    .rateFull (mode.rateFull),
    .count    (count)
  );

  // Two flops on the trip pin before anything reads it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tripMeta <= 1'b1;
      tripSync <= 1'b1;
    end else begin
      tripMeta <= faultTripInput_n;
      tripSync <= tripMeta;
    end
  end

  // Shutdown latch; a trip or request in the release cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shutdown <= 1'b0;
    end else if (shutSet) begin
      shutdown <= 1'b1;
    end else if (shutClr) begin
      shutdown <= 1'b0;
    end
  end

  // Software source flag, cleared by reading; a new request beats the read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      swSource <= 1'b0;
    end else if (swShutReq) begin
      swSource <= 1'b1;
    end else if (rdShut) begin
      swSource <= 1'b0;
    end
  end

  // Per-channel synchronise, capture and publish
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : lane
      // A trip in the very last cycle still counts
      wire [COUNT_WIDTH-1:0] endValue =
        captured[ch] ? capture[ch] :
        (tripEdge[ch] ? count : COUNT_ZERO);

      // Comparator synchroniser; only the second and third stages are looked at
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          compMeta[ch] <= 1'b0;
          compSync[ch] <= 1'b0;
          compLast[ch] <= 1'b0;
        end else begin
          compMeta[ch] <= compTrip[ch];
          compSync[ch] <= compMeta[ch];
          compLast[ch] <= compSync[ch];
        end
      end

      // First trip of the period latches the shared timer
      always_ff @(posedge clk) begin
        if (!rst_n || clearCnt) begin
          captured[ch] <= 1'b0;
          capture[ch]  <= COUNT_ZERO;
        end else if (counting && tripEdge[ch] && !captured[ch]) begin
          captured[ch] <= 1'b1;
          capture[ch]  <= count;
        end
      end

      // Results change only at period end, so reads stay stable
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          result[ch] <= COUNT_ZERO;
        end else if (periodEnd) begin
          result[ch] <= endValue;
        end
      end
    end
  endgenerate

  // Mode register: aux select, rate and update mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode <= '0;
    end else if (wrMode) begin
      mode.auxSelect    <= busReq.wdata[SEL_HI_BIT:SEL_LO_BIT];
      mode.rateFull     <= busReq.wdata[RATE_BIT];
      mode.doubleUpdate <= busReq.wdata[DOUBLE_BIT];
    end
  end

  // Pulse width in clocks; software must cover a full discharge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cyclePulseWidth <= WIDTH_RESET;
    end else if (wrWidth) begin
      cyclePulseWidth <= busReq.wdata[WIDTH_BITS-1:0];
    end
  end

  // Trim straight to the current source, zero after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rampCurrentTrim <= TRIM_RESET;
    end else if (wrTrim) begin
      rampCurrentTrim <= busReq.wdata[2:0];
    end
  end

  // Multiplexer select pins follow the mode register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      auxSelect <= 2'h0;
    end else begin
      auxSelect <= mode.auxSelect;
    end
  end

  // Read multiplexer; unmapped addresses read zero
  wire [DATA_WIDTH-1:0] modeWord =
    {6'h00, mode.doubleUpdate, 1'b0, mode.rateFull, 5'h00, mode.auxSelect};
  wire [DATA_WIDTH-1:0] shutWord =
    {13'h0000, swSource, tripSync, shutdown};
  wire [DATA_WIDTH-1:0] readWord =
    hitMode   ? modeWord :
    hitWidth  ? {8'h00, cyclePulseWidth} :
    hitTrim   ? {13'h0000, rampCurrentTrim} :
    hitShut   ? shutWord :
    hitResult ? {4'h0, result[resultIdx]} :
    16'h0000;

  // Read data stands one cycle after the strobe and only then
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData <= 16'h0000;
    end else if (busReq.rd) begin
      rdData <= readWord;
    end else begin
      rdData <= 16'h0000;
    end
  end
endmodule

//--- tb/ssadc_monitor.sv
/*
  Port-level checks on the converter timer: pulse, trim, select, fault.
  Assumes it is bound onto single_slope_adc_timer and sees only its ports.
*/
`timescale 1ns/1ps
module ssadc_monitor (
  // Clock and reset
  input wire logic                             clk,
  input wire logic                             rst_n,
  // Register port
  input wire ssadc_pkg::bus_req_type           busReq,
  input wire logic [ssadc_pkg::DATA_WIDTH-1:0] rdData,
  // PWM strobes, fault pin and comparator outputs
  input wire logic                             pwmStart,
  input wire logic                             pwmMidpoint,
  input wire logic                             faultTripInput_n,
  input wire logic [ssadc_pkg::CHANNELS-1:0]   compTrip,
  // Analog controls
  input wire logic                             pwmCyclePulse,
  input wire logic [1:0]                       auxSelect,
  input wire logic [2:0]                       rampCurrentTrim
);
  import ssadc_pkg::*;
  logic [15:0] pulseLen;
  wire         trimWrite = busReq.wr && busReq.addr == TRIM_OFFSET;
  wire         modeWrite = busReq.wr && busReq.addr == MODE_OFFSET;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Clocks spent high by the current pulse; a restart only lengthens it
  always_ff @(posedge clk) begin
    pulseLen <= pwmCyclePulse ? pulseLen + 16'h0001 : 16'h0000;
  end
  // Pulse and conversion start
  a_pulse_cause: assert property ($rose(pwmCyclePulse) |-> $past(pwmStart || pwmMidpoint))
    else $error("discharge pulse rose without a strobe");
  a_pulse_min: assert property ($fell(pwmCyclePulse) && faultTripInput_n |->
    pulseLen >= 16'(MIN_PULSE_CYC)) else $error("discharge pulse too short");
  a_fault_block: assert property ((!faultTripInput_n) [*5] |=> !$rose(pwmCyclePulse))
    else $error("pulse started while the fault pin is low");
  // Trim and select registers
  a_trim_write: assert property (trimWrite |=> rampCurrentTrim == $past(busReq.wdata[2:0]))
    else $error("trim output does not follow the write");
  a_trim_hold: assert property (!trimWrite |=> $stable(rampCurrentTrim))
    else $error("trim output changed without a write");
  a_trim_reset: assert property ($rose(rst_n) |-> rampCurrentTrim == TRIM_RESET)
    else $error("trim not zero after reset");
  // Select pins trail the mode register by one more flop, so two edges after the write
  a_aux_write: assert property (modeWrite |-> ##2 auxSelect == $past(busReq.wdata[1:0], 2))
    else $error("aux select does not follow the write");
  a_aux_hold: assert property (!modeWrite |=> ##1 $stable(auxSelect))
    else $error("aux select changed without a write");
  // Main scenarios reached
  c_pulse_run: cover property ($fell(pwmCyclePulse));
  c_result_read: cover property (busReq.rd && busReq.addr >= RESULT_OFFSET);
  c_fault_hold: cover property ((!faultTripInput_n) [*5]);
endmodule

//--- tb/ramp_model.sv
/*
  Far side of the timer: ramp capacitor and four comparators.
  Assumes the bench sets trip delays in clocks after discharge; zero never trips.
*/
`timescale 1ns/1ps
module ramp_model (
  // Clock
  input  wire logic       clk,
  // From the timer block
  input  wire logic       pwmCyclePulse,
  input  wire logic [1:0] auxSelect,
  input  wire logic [2:0] rampCurrentTrim,
  // Delays: main 0..2, aux 3..5 for select 0..2, reference 6 at trim zero
  input  var  int         tripDelay [7],
  // Comparator outputs
  output logic [3:0]      compTrip
);
  int elapsed = 0;
  int auxDelay;
  // Ramp sits at zero during discharge, then rises
  always @(posedge clk) elapsed <= pwmCyclePulse ? 0 : elapsed + 1;
  // More current makes a steeper ramp, so the reference trips earlier
  assign auxDelay = (auxSelect == 2'h3) ? tripDelay[6] - 16 * rampCurrentTrim
                                        : tripDelay[3 + auxSelect];
  // One ramp for all comparators, so all share the start instant
  assign compTrip[0] = !pwmCyclePulse && tripDelay[0] > 0 && elapsed >= tripDelay[0];
  assign compTrip[1] = !pwmCyclePulse && tripDelay[1] > 0 && elapsed >= tripDelay[1];
  assign compTrip[2] = !pwmCyclePulse && tripDelay[2] > 0 && elapsed >= tripDelay[2];
  assign compTrip[3] = !pwmCyclePulse && auxDelay > 0 && elapsed >= auxDelay;
endmodule

//--- tb/single_slope_adc_timer_tb.sv
/*
  Self-checking bench: registers, pulse width, conversions, aux select, shutdown.
  Assumes ramp_model on the comparator side and ssadc_monitor bound in.
*/
`timescale 1ns/1ps
module single_slope_adc_timer_tb;
  import ssadc_pkg::*;
  logic                  clk              = 1'b0;
  logic                  rst_n            = 1'b0;
  bus_req_type           busReq           = '0;
  logic                  pwmStart         = 1'b0;
  logic                  pwmMidpoint      = 1'b0;
  logic                  faultTripInput_n = 1'b1;
  int                    tripDelay [7]    = '{default: 0};
  logic [DATA_WIDTH-1:0] rdData;
  logic [CHANNELS-1:0]   compTrip;
  logic                  pwmCyclePulse;
  logic [1:0]            auxSelect;
  logic [2:0]            rampCurrentTrim;
  int                    error_cnt        = 0;
  int                    cmp_count        = 0;
  int                    n;
  logic [15:0]           res [4];
  logic [1:0]            selTab [5]       = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  int                    trimTab [5]      = '{0, 0, 0, 0, 4};
  logic [15:0]           resetExp [9]     = '{16'h0000, 16'h0080, 16'h0000, 16'h0002,
                                              16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  always #2 clk = ~clk;

  single_slope_adc_timer i_single_slope_adc_timer (.clk(clk), .rst_n(rst_n), .busReq(busReq),
    .rdData(rdData), .pwmStart(pwmStart), .pwmMidpoint(pwmMidpoint),
    .faultTripInput_n(faultTripInput_n), .compTrip(compTrip), .pwmCyclePulse(pwmCyclePulse),
    .auxSelect(auxSelect), .rampCurrentTrim(rampCurrentTrim));
  ramp_model i_ramp_model (.clk(clk), .pwmCyclePulse(pwmCyclePulse), .auxSelect(auxSelect),
    .rampCurrentTrim(rampCurrentTrim), .tripDelay(tripDelay), .compTrip(compTrip));

  task automatic finish_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus cycles: one strobe cycle, then one idle edge so no signal is set twice at once
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    busReq <= '0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] e, input string what);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    busReq <= '0;
    #1 chk(what, e, rdData);
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    busReq <= '0;
    #1 d = rdData;
    @(posedge clk);
  endtask
  // Strobe returns at its taking edge so the rise of the pulse is never missed
  task automatic strobe(input logic s, input logic m);
    pwmStart <= s;
    pwmMidpoint <= m;
    @(posedge clk);
    pwmStart <= 1'b0;
    pwmMidpoint <= 1'b0;
  endtask
  task automatic pulse_is(input logic e);
    @(posedge clk);
    #1 chk("pulse", 16'(e), 16'(pwmCyclePulse));
    @(posedge clk);
  endtask
  task automatic wait_pulse(input logic lvl, input int bound);
    n = 0;
    #1;
    while (pwmCyclePulse !== lvl) begin
      if (n == bound) begin
        error_cnt++;
        finish_test();
      end
      n++;
      @(posedge clk);
      #1;
    end
    @(posedge clk);
  endtask
  // One full period of w clocks after discharge, then publish and read all results
  task automatic run_conv(input int w);
    strobe(1'b1, 1'b0);
    wait_pulse(1'b1, 3);
    wait_pulse(1'b0, 300);
    repeat (w) @(posedge clk);
    strobe(1'b1, 1'b0);
    repeat (3) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      rd(RESULT_OFFSET + 4'(k), res[k]);
    end
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 9; a++) begin
      rchk(4'(a), resetExp[a], "reset value");
    end
    wr(TRIM_OFFSET, 16'hffff);
    rchk(TRIM_OFFSET, 16'h0007, "trim");
    wr(4'h8, 16'h1234);
    rchk(4'h8, 16'h0000, "unmapped");
    // Pulse width as set, and the floor; the first high cycle is not counted
    wr(WIDTH_OFFSET, 16'h0014);
    strobe(1'b1, 1'b0);
    wait_pulse(1'b1, 3);
    wait_pulse(1'b0, 300);
    chk("pulse width", 16'h0013, 16'(n));
    wr(WIDTH_OFFSET, 16'h0005);
    strobe(1'b1, 1'b0);
    wait_pulse(1'b1, 3);
    wait_pulse(1'b0, 300);
    chk("pulse floor", 16'(MIN_PULSE_CYC - 1), 16'(n));
    // Count differences cancel the fixed capture latency
    tripDelay = '{100, 300, 0, 150, 160, 170, 250};
    for (int k = 0; k < 5; k++) begin
      wr(TRIM_OFFSET, 16'(trimTab[k]));
      wr(MODE_OFFSET, 16'h0080 | {14'h0000, selTab[k]});
      run_conv(400);
      chk("ch1-ch0", 16'h00c8, res[1] - res[0]);
      chk("no trip", 16'h0000, res[2]);
      chk("aux-ch0", (selTab[k] == 2'h3) ? 16'(150 - 16 * trimTab[k]) :
          16'(tripDelay[3 + selTab[k]] - 100), res[3] - res[0]);
    end
    wr(MODE_OFFSET, 16'h0000);
    run_conv(800);
    chk("half ch1-ch0", 16'h0064, res[1] - res[0]);
    chk("half aux-ch0", 16'h0019, res[3] - res[0]);
    tripDelay[0] = 4200;
    wr(MODE_OFFSET, 16'h0080);
    run_conv(4300);
    chk("top count", 16'h0fff, res[0]);
    // Calibration: trim steps up from zero on the reference until below target
    tripDelay[6] = 350;
    wr(MODE_OFFSET, 16'h0083);
    for (int t = 0; t < 8; t++) begin
      wr(TRIM_OFFSET, 16'(t));
      run_conv(400);
      if (res[3] < 16'(400 * 5 / 7)) break;
    end
    rchk(TRIM_OFFSET, 16'h0005, "calibrated trim");
    // Midpoint starts a period only in double update mode; start from a low pulse
    wr(MODE_OFFSET, 16'h0280);
    wait_pulse(1'b0, 300);
    strobe(1'b0, 1'b1);
    pulse_is(1'b1);
    wait_pulse(1'b0, 300);
    wr(MODE_OFFSET, 16'h0080);
    strobe(1'b0, 1'b1);
    pulse_is(1'b0);
    // Pin shutdown, then restart once the pin is high again
    faultTripInput_n <= 1'b0;
    repeat (6) @(posedge clk);
    strobe(1'b1, 1'b0);
    pulse_is(1'b0);
    rchk(SHUT_OFFSET, 16'h0001, "pin shutdown");
    faultTripInput_n <= 1'b1;
    repeat (6) @(posedge clk);
    wr(SHUT_OFFSET, 16'h0002);
    strobe(1'b1, 1'b0);
    pulse_is(1'b1);
    wait_pulse(1'b0, 300);
    // Software shutdown; the source flag clears on read
    wr(SHUT_OFFSET, 16'h0001);
    strobe(1'b1, 1'b0);
    pulse_is(1'b0);
    rchk(SHUT_OFFSET, 16'h0007, "sw shutdown");
    rchk(SHUT_OFFSET, 16'h0003, "sw flag cleared");
    wr(SHUT_OFFSET, 16'h0002);
    rchk(SHUT_OFFSET, 16'h0002, "reinit");
    strobe(1'b1, 1'b0);
    pulse_is(1'b1);
    // Reset in mid-run
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(TRIM_OFFSET, 16'h0000, "trim after reset");
    finish_test();
  end
endmodule

bind single_slope_adc_timer ssadc_monitor i_ssadc_monitor (.clk(clk), .rst_n(rst_n),
  .busReq(busReq), .rdData(rdData), .pwmStart(pwmStart), .pwmMidpoint(pwmMidpoint),
  .faultTripInput_n(faultTripInput_n), .compTrip(compTrip), .pwmCyclePulse(pwmCyclePulse),
  .auxSelect(auxSelect), .rampCurrentTrim(rampCurrentTrim));
